// File: rtl/swr_consts.vh
// Constants for the single-wire ROM search slave
`ifndef SWR_CONSTS_VH
`define SWR_CONSTS_VH
`define SWR_CLK_MHZ        40
`define SWR_T_RESET_US     560
`define SWR_T_PD_WAIT_US   15
`define SWR_T_PD_LOW_US    70
`define SWR_T_LOW_US       1
`define SWR_T_HOLD_US      14
`define SWR_T_PHASE_US     70
`define SWR_CMD_SEARCH     8'hf0
`define SWR_CMD_READ       8'h33
`define SWR_ROM_BITS       64
`define SWR_CMD_BITS       8
`define SWR_FIFO_DEPTH     32
`define SWR_CNT_W          16
`endif

// File: rtl/swr_fifo.v
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
`default_nettype none
module swr_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk_i,
  input  wire             sys_rst_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push = in_valid_i && in_ready_o;
  wire            pop  = out_valid_o && out_ready_i;

  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o  = mem_q[rd_q];

  // Pointers wrap modulo depth, depth must be a power of two
  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
    if (sys_rst_i) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // swr_fifo
`default_nettype wire

// File: rtl/swr_slave.v
// Single-wire slave: reset/presence, command, ROM read and search
`timescale 1ns/1ps
`default_nettype none
`include "swr_consts.vh"
module swr_slave #(
  parameter [63:0] ROM_CODE  = 64'h00_000000000000_01, // Arbitrary value
  parameter        RESET_CYC = `SWR_T_RESET_US * `SWR_CLK_MHZ
) (
  input  wire       clk_i,
  input  wire       sys_rst_i,
  input  wire       line_i,
  output reg        line_o,
  output reg        line_oe_o,
  output reg  [7:0] cmd_data_o,
  output reg        cmd_valid_o,
  input  wire       cmd_ready_i,
  output reg        presence_o,
  output reg        selected_o
);
  localparam CW         = `SWR_CNT_W;
  // Cycle counts are worked out at full width, then cut to the counter width
  localparam integer  N_PHASE = (`SWR_T_LOW_US + `SWR_T_PHASE_US) * `SWR_CLK_MHZ;
  localparam integer  N_HOLD  = (`SWR_T_LOW_US + `SWR_T_HOLD_US) * `SWR_CLK_MHZ;
  localparam integer  N_PDW   = `SWR_T_PD_WAIT_US * `SWR_CLK_MHZ;
  localparam integer  N_PDL   = `SWR_T_PD_LOW_US * `SWR_CLK_MHZ;
  localparam integer  N_RST   = RESET_CYC;
  localparam [CW-1:0] C_PHASE = N_PHASE[CW-1:0];
  localparam [CW-1:0] C_HOLD  = N_HOLD[CW-1:0];
  localparam [CW-1:0] C_PDW   = N_PDW[CW-1:0];
  localparam [CW-1:0] C_PDL   = N_PDL[CW-1:0];
  localparam [CW-1:0] C_RST   = N_RST[CW-1:0];
  // First slot count at which a rise no longer falls inside the write phase
  localparam [CW-1:0] C_ONE_END = C_PHASE - 1'b1;

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_PDW  = 3'd1;
  localparam [2:0] ST_PDL  = 3'd2;
  localparam [2:0] ST_CMD  = 3'd3;
  localparam [2:0] ST_READ = 3'd4;
  localparam [2:0] ST_SRCH = 3'd5;
  localparam [2:0] ST_DATA = 3'd6;

  localparam [1:0] PH_TRUE = 2'd0;
  localparam [1:0] PH_INV  = 2'd1;
  localparam [1:0] PH_SEL  = 2'd2;

  // Three-stage synchroniser; a change counts when stages two and three agree
  reg          s1_q;
  reg          s2_q;
  reg          s3_q;
  reg          ln_q;
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      ln_q <= 1'b1;
    end else begin
      s1_q <= line_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        ln_q <= s3_q;
      end
    end
  end
  wire         ln_d  = (s2_q == s3_q) ? s3_q : ln_q;
  wire         fall  = ln_q && !ln_d;
  wire         rise  = !ln_q && ln_d;

  reg [2:0]    st_q;
  reg [CW-1:0] low_q;     // Low-time counter for bus reset detection
  reg [CW-1:0] t_q;       // Time since slot start
  reg          slot_q;    // Slot in progress
  reg          one_q;     // Rising edge seen in write phase
  reg [5:0]    bit_q;
  reg [7:0]    sh_q;
  reg [1:0]    ph_q;
  reg          drv_q;     // Pull low in the present read slot
  wire         rom_bit = ROM_CODE[bit_q];
  wire         bus_rst = !ln_q && (low_q >= C_RST);
  wire         wbit    = one_q; // A rise at the slot-end edge lies past the phase

  // FIFO carries received data bytes to the user side; full stalls reception
  wire         f_ready;
  wire [7:0]   f_data;
  wire         f_valid;
  wire         f_take  = f_valid && (!cmd_valid_o || cmd_ready_i);
  reg  [7:0]   push_data_q;
  reg          push_q;

  swr_fifo #(
    .WIDTH (8),
    .DEPTH (`SWR_FIFO_DEPTH),
    .AW    (5)
  ) u_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   (push_data_q),
    .in_valid_i  (push_q),
    .in_ready_o  (f_ready),
    .out_data_o  (f_data),
    .out_valid_o (f_valid),
    .out_ready_i (f_take)
  );

  // Output stage holds one byte; the FIFO pops only when that stage is free or drained,
  // so no byte is lost while the user stalls
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      cmd_data_o  <= 8'h00;
      cmd_valid_o <= 1'b0;
    end else if (f_take) begin
      cmd_data_o  <= f_data;
      cmd_valid_o <= 1'b1;
    end else if (cmd_ready_i) begin
      cmd_valid_o <= 1'b0;
    end
  end

  // Main protocol sequencer
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q        <= ST_IDLE;
      low_q       <= {CW{1'b0}};
      t_q         <= {CW{1'b0}};
      slot_q      <= 1'b0;
      one_q       <= 1'b0;
      bit_q       <= 6'd0;
      sh_q        <= 8'h00;
      ph_q        <= PH_TRUE;
      drv_q       <= 1'b0;
      line_o      <= 1'b0;
      line_oe_o   <= 1'b0;
      presence_o  <= 1'b0;
      selected_o  <= 1'b0;
      push_q      <= 1'b0;
      push_data_q <= 8'h00;
    end else begin
      push_q <= 1'b0;
      line_o <= 1'b0;
      // Saturating low-time counter
      if (ln_q) begin
        low_q <= {CW{1'b0}};
      end else if (low_q != C_RST) begin
        low_q <= low_q + 1'b1;
      end
      if (slot_q && t_q != {CW{1'b1}}) begin
        t_q <= t_q + 1'b1;
      end
      // Fall and rise pass the same synchroniser, so t_q measures the true low time;
      // the release that ends a written zero lands just outside this window
      if (slot_q && rise && t_q < C_ONE_END) begin
        one_q <= 1'b1;
      end
      if (bus_rst) begin
        // Long low aborts anything, then waits for release
        st_q       <= ST_PDW;
        t_q        <= {CW{1'b0}};
        slot_q     <= 1'b0;
        line_oe_o  <= 1'b0;
        drv_q      <= 1'b0;
        selected_o <= 1'b0;
      end else begin
        case (st_q)
          ST_IDLE: begin
            line_oe_o <= 1'b0;
          end
          ST_PDW: begin
            // Count the wait only after the line has returned high
            if (!ln_q) begin
              t_q <= {CW{1'b0}};
            end else if (t_q >= C_PDW) begin
              st_q      <= ST_PDL;
              t_q       <= {CW{1'b0}};
              line_oe_o <= 1'b1;
            end else begin
              t_q <= t_q + 1'b1;
            end
          end
          ST_PDL: begin
            t_q <= t_q + 1'b1;
            if (t_q >= C_PDL - 1'b1) begin
              line_oe_o  <= 1'b0;
              presence_o <= 1'b1;
              st_q       <= ST_CMD;
              bit_q      <= 6'd0;
              slot_q     <= 1'b0;
            end
          end
          default: begin
            // Slot start on a falling edge; reception pauses while FIFO is full
            if (fall && !slot_q && (st_q != ST_DATA || f_ready)) begin
              slot_q <= 1'b1;
              t_q    <= {CW{1'b0}};
              one_q  <= 1'b0;
              if (st_q == ST_READ || (st_q == ST_SRCH && ph_q != PH_SEL)) begin
                drv_q     <= (st_q == ST_SRCH && ph_q == PH_INV) ? rom_bit : !rom_bit;
                line_oe_o <= (st_q == ST_SRCH && ph_q == PH_INV) ? rom_bit : !rom_bit;
              end
            end else if (slot_q && drv_q && t_q >= C_HOLD) begin
              line_oe_o <= 1'b0;
              drv_q     <= 1'b0;
            end else if (slot_q && !drv_q && t_q >= C_PHASE) begin
              slot_q    <= 1'b0;
              line_oe_o <= 1'b0;
              case (st_q)
                ST_CMD: begin
                  sh_q  <= {wbit, sh_q[7:1]};
                  bit_q <= bit_q + 1'b1;
                  if (bit_q == `SWR_CMD_BITS - 1) begin
                    bit_q <= 6'd0;
                    ph_q  <= PH_TRUE;
                    if ({wbit, sh_q[7:1]} == `SWR_CMD_SEARCH) begin
                      st_q <= ST_SRCH;
                    end else if ({wbit, sh_q[7:1]} == `SWR_CMD_READ) begin
                      st_q <= ST_READ;
                    end else begin
                      st_q <= ST_DATA;
                    end
                  end
                end
                ST_READ: begin
                  bit_q <= bit_q + 1'b1;
                  if (bit_q == `SWR_ROM_BITS - 1) begin
                    st_q  <= ST_DATA;
                    bit_q <= 6'd0;
                  end
                end
                ST_SRCH: begin
                  if (ph_q == PH_SEL) begin
                    ph_q  <= PH_TRUE;
                    bit_q <= bit_q + 1'b1;
                    if (wbit != rom_bit) begin
                      st_q <= ST_IDLE;
                    end else if (bit_q == `SWR_ROM_BITS - 1) begin
                      selected_o <= 1'b1;
                      st_q       <= ST_DATA;
                      bit_q      <= 6'd0;
                    end
                  end else begin
                    ph_q <= ph_q + 1'b1;
                  end
                end
                default: begin
                  // Data bytes after the command go to the FIFO
                  sh_q  <= {wbit, sh_q[7:1]};
                  bit_q <= bit_q + 1'b1;
                  if (bit_q == `SWR_CMD_BITS - 1) begin
                    bit_q       <= 6'd0;
                    push_q      <= 1'b1;
                    push_data_q <= {wbit, sh_q[7:1]};
                  end
                end
              endcase
            end
          end
        endcase
      end
    end
  end
endmodule // swr_slave
`default_nettype wire

// File: tb/swr_slave_chk_asserts.sv
// Pin timing checker for the single-wire slave
`timescale 1ns/1ps
`default_nettype none
module swr_slave_chk (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       line_i,
  input wire logic       line_o,
  input wire logic       line_oe_o,
  input wire logic [7:0] cmd_data_o,
  input wire logic       cmd_valid_o,
  input wire logic       cmd_ready_i,
  input wire logic       presence_o,
  input wire logic       selected_o
);
  logic [15:0] hi_q;
  logic [15:0] lo_q;
  logic [15:0] up_q;
  // Run lengths of our drive, of line low and of line high; the two line counts saturate
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hi_q <= 16'h0000;
      lo_q <= 16'h0000;
      up_q <= 16'h0000;
    end else begin
      hi_q <= line_oe_o ? hi_q + 16'h0001 : 16'h0000;
      lo_q <= line_i ? 16'h0000 : lo_q + {15'h0000, lo_q != 16'hffff};
      up_q <= !line_i ? 16'h0000 : up_q + {15'h0000, up_q != 16'hffff};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_line_zero: assert property (line_o == 1'b0) else $error("line driven high");
  a_rst_quiet: assert property ($fell(sys_rst_i) |-> !line_oe_o && !presence_o && !selected_o && !cmd_valid_o)
    else $error("outputs active after reset");
  a_pres_wait: assert property ($rose(line_oe_o) && $past(line_i) |-> up_q >= 600 && up_q <= 2800)
    else $error("presence start out of window");
  a_read_start: assert property ($rose(line_oe_o) && !$past(line_i) |-> lo_q <= 40)
    else $error("read bit driven late");
  a_pres_len: assert property ($fell(line_oe_o) && hi_q > 1500 |-> hi_q >= 2799 && hi_q <= 2801)
    else $error("presence pulse length wrong");
  a_read_hold: assert property ($fell(line_oe_o) && hi_q <= 1500 |-> lo_q >= 600 && lo_q <= 2400)
    else $error("read bit hold wrong");
  a_drive_max: assert property (hi_q <= 2801) else $error("line held low too long");
  a_pres_keep: assert property (!$fell(presence_o)) else $error("presence flag dropped");
  c_presence: cover property ($fell(line_oe_o) && hi_q > 1500);
  c_read_zero: cover property ($fell(line_oe_o) && hi_q <= 1500);
  c_pres_flag: cover property ($rose(presence_o));
endmodule // swr_slave_chk
bind swr_slave swr_slave_chk u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .line_i(line_i), .line_o(line_o),
  .line_oe_o(line_oe_o), .cmd_data_o(cmd_data_o), .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i),
  .presence_o(presence_o), .selected_o(selected_o));
`default_nettype wire

// File: tb/swr_mst_model.sv
// Behavioural single-wire bus master
`timescale 1ns/1ps
`default_nettype none
module swr_mst_model #(
  parameter int RST_CYC = 400
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  output var  logic pull_low_o
);
  initial pull_low_o = 1'b0;
  // Wait n edges, then change just after the edge
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Long low resets every slave, then watch for presence
  task automatic bus_reset(output logic seen);
    seen = 1'b0;
    pull_low_o = 1'b1;
    hold(RST_CYC + 40);
    pull_low_o = 1'b0;
    for (int i = 0; i < 3600; i++) begin
      hold(1);
      if (line_i === 1'b0) seen = 1'b1;
    end
  endtask
  // Random recovery time after release exercises slot spacing
  task automatic write_bit(input logic b);
    pull_low_o = 1'b1;
    hold(40);
    pull_low_o = !b;
    hold(2800);
    pull_low_o = 1'b0;
    hold(40 + $urandom_range(39));
  endtask
  task automatic write_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) write_bit(v[i]);
  endtask
  // Sample a little early, while a slave zero is still held low
  task automatic read_bit(output logic b);
    pull_low_o = 1'b1;
    hold(40);
    pull_low_o = 1'b0;
    hold(520);
    b = line_i;
    hold(2280);
    hold(40 + $urandom_range(39));
  endtask
endmodule // swr_mst_model
`default_nettype wire

// File: tb/swr_slave_tb.sv
// Self-checking bench: presence, search drop-out and ROM readout
`timescale 1ns/1ps
`default_nettype none
module swr_slave_tb;
  localparam logic [63:0] ROM = 64'h5a_0123456789ab_c6; // Arbitrary value
  logic       clk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       cmd_ready_i = 1'b0;
  logic       line_o, line_oe_o, cmd_valid_o, presence_o, selected_o, pull_low, seen, t, c;
  logic [7:0] cmd_data_o;
  logic [7:0] crc_seen = 8'h00;
  logic [7:0] crc_exp = 8'h00;
  wire logic  line_i;
  int         fail_count = 0;
  int         total_checks = 0;
  always #12.5 clk_i = ~clk_i;
  // Pull-up wins unless some party pulls low
  assign line_i = ~pull_low & ~(line_oe_o & ~line_o);
  // Short reset for speed, yet above the 71us low of a written zero
  swr_slave #(.ROM_CODE(ROM), .RESET_CYC(3000)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .line_i(line_i),
    .line_o(line_o), .line_oe_o(line_oe_o), .cmd_data_o(cmd_data_o), .cmd_valid_o(cmd_valid_o),
    .cmd_ready_i(cmd_ready_i), .presence_o(presence_o), .selected_o(selected_o));
  swr_mst_model #(.RST_CYC(3000)) u_mst (.clk_i(clk_i), .line_i(line_i), .pull_low_o(pull_low));
  // Random consumer stalls
  always @(posedge clk_i) cmd_ready_i <= #1 1'($urandom_range(1));
  function automatic logic rom_bit(input int i);
    return ROM[i];
  endfunction
  // Reflected x^8+x^5+x^4+1, one bit at a time, low bit first
  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic b);
    return (crc >> 1) ^ ((crc[0] ^ b) ? 8'h8c : 8'h00);
  endfunction
  task automatic check(input logic [7:0] seen_v, input logic [7:0] exp_v);
    total_checks++;
    if (seen_v !== exp_v) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Watchdog against a hung slave
  initial begin
    repeat (99000) @(posedge clk_i);
    fail_count++;
    finish_test();
  end
  initial begin
    void'($urandom(52));
    repeat (6) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    check(line_oe_o | presence_o | selected_o | cmd_valid_o, 1'b0);
    u_mst.bus_reset(seen);
    check(seen, 1'b1);
    check(presence_o, 1'b1);
    u_mst.write_byte(8'hf0);
    // Match the first select, break the second
    for (int i = 0; i < 2; i++) begin
      u_mst.read_bit(t);
      u_mst.read_bit(c);
      check(t, rom_bit(i));
      check(c, !rom_bit(i));
      u_mst.write_bit(rom_bit(i) ^ (i == 1));
    end
    u_mst.read_bit(t);
    u_mst.read_bit(c);
    check(t, 1'b1);
    check(c, 1'b1);
    check(selected_o, 1'b0);
    u_mst.bus_reset(seen);
    check(seen, 1'b1);
    u_mst.write_byte(8'h33);
    for (int i = 0; i < 4; i++) begin
      u_mst.read_bit(t);
      check(t, rom_bit(i));
      crc_seen = crc_step(crc_seen, t);
      crc_exp  = crc_step(crc_exp, rom_bit(i));
    end
    check(crc_seen, crc_exp);
    check(cmd_valid_o, 1'b0);
    check(cmd_data_o, 8'h00);
    finish_test();
  end
endmodule // swr_slave_tb
`default_nettype wire
